// *** bench/hpfo_props.sv ***
// concurrent checks on the pins and register port between the two ends
`timescale 1ns/1ps
module hpfo_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic [1:0] mainEnable,
  input wire logic [1:0] auxEnable,
  input wire logic [1:0] overrideN,
  input wire logic [1:0] faultOe,
  input wire logic [1:0] powerGoodOe,
  input wire logic irqOe,
  input wire hpfo_pkg::hpfo_addr_t regAddr,
  input wire hpfo_pkg::hpfo_byte_t regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire hpfo_pkg::hpfo_byte_t regRdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic maskQ, maskD, ovrDisQ, ovrDisD;
  logic [1:0] lowCntQ, lowCntD, ovrCntQ, ovrCntD;
  // shadows of the mask and override-disable bits, plus saturating counts of settled pin states
  always_comb begin
    maskD = (regWr && regAddr == 4'h4) ? regWdata[3] : maskQ;
    ovrDisD = (regWr && regAddr == 4'h0) ? regWdata[2] : ovrDisQ;
    lowCntD = (mainEnable[0] || !overrideN[0]) ? 2'h0 : lowCntQ + {1'b0, lowCntQ != 2'h3};
    ovrCntD = (overrideN[0] || ovrDisQ) ? 2'h0 : ovrCntQ + {1'b0, ovrCntQ != 2'h3};
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      maskQ <= 1'b0;
      ovrDisQ <= 1'b0;
      lowCntQ <= 2'h0;
      ovrCntQ <= 2'h0;
    end else begin
      maskQ <= maskD;
      ovrDisQ <= ovrDisD;
      lowCntQ <= lowCntD;
      ovrCntQ <= ovrCntD;
    end
  end
  rd_idle_a: assert property (!$past(regRd) |-> regRdata == 8'h00) else $error("read data outside its slot");
  rd_unmapped_a: assert property ($past(regRd) && $past(regAddr) > 4'h5 |-> regRdata == 8'h00)
    else $error("unmapped read not zero");
  irq_mask_a: assert property (maskQ && $past(maskQ) |-> !irqOe) else $error("irq while masked");
  irq_rise_a: assert property ($rose(irqOe) |-> !maskQ) else $error("irq rose under mask");
  irq_hold_a: assert property (irqOe && !regWr && !$past(regWr) |=> irqOe) else $error("irq dropped");
  fault_hold_a: assert property (faultOe[0] && mainEnable[0] && auxEnable[0] && $past(mainEnable[0] && auxEnable[0])
    ##1 overrideN[0] |-> faultOe[0]) else $error("fault released early");
  pg_off_a: assert property (lowCntQ == 2'h3 |-> !powerGoodOe[0]) else $error("power good with mains off");
  ovr_rel_a: assert property (ovrCntQ == 2'h3 |-> !faultOe[0] && !powerGoodOe[0])
    else $error("pins driven during override");
  cover property (ovrCntQ == 2'h3);
  cover property ($fell(irqOe));
  cover property ($rose(faultOe[0]));
endmodule // hpfo_props

// *** bench/hpfo_tb.sv ***
// self-checking bench joining both ends of the hot-plug fault/override logic
`timescale 1ns/1ps
module hpfo_tb;
  logic clk;
  logic srst;
  logic [2:0] cmdAddr;
  logic [7:0] cmdWdata;
  logic cmdWr;
  logic cmdRd;
  logic [7:0] cmdRdata;
  logic hostIrq;
  logic [1:0] mainOcTrip, mainInUv, auxOcTrip, overTemp, generalInput, mainSwitchOn, auxSwitchOn;
  logic auxUvlo;
  logic [1:0] delivering;
  logic standbyGood;
  logic [2:0] addrSelect;
  logic [6:0] smbusAddr;
  logic [7:0] d;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  hpfo_if link();
  hpfo_device i_hpfo_device (.clk(clk), .srst(srst), .link(link), .mainOcTrip(mainOcTrip), .mainInUv(mainInUv),
    .auxOcTrip(auxOcTrip), .overTemp(overTemp), .auxUvlo(auxUvlo), .mainDelivering(delivering),
    .auxDelivering(delivering),
    .generalInput(generalInput), .addrSelect(addrSelect), .standbyGood(standbyGood),
    .mainSwitchOn(mainSwitchOn), .auxSwitchOn(auxSwitchOn), .smbusAddr(smbusAddr));
  hpfo_host i_hpfo_host (.clk(clk), .srst(srst), .link(link), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
    .cmdWr(cmdWr), .cmdRd(cmdRd), .cmdRdata(cmdRdata), .hostIrq(hostIrq));
  hpfo_props i_hpfo_props (.clk(clk), .srst(srst), .mainEnable(link.mainEnable), .auxEnable(link.auxEnable),
    .overrideN(link.overrideN), .faultOe(link.faultOe), .powerGoodOe(link.powerGoodOe), .irqOe(link.irqOe),
    .regAddr(link.regAddr), .regWdata(link.regWdata), .regWr(link.regWr), .regRd(link.regRd),
    .regRdata(link.regRdata));
  task automatic conclude();
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] v);
    @(posedge clk);
    cmdAddr <= a;
    cmdWdata <= v;
    cmdWr <= 1'b1;
    @(posedge clk);
    cmdWr <= 1'b0;
  endtask
  task automatic rd(logic [2:0] a);
    @(posedge clk);
    cmdAddr <= a;
    cmdRd <= 1'b1;
    @(posedge clk);
    cmdRd <= 1'b0;
    #1 d = cmdRdata;
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  task automatic pins(logic [7:0] v);
    wr(3'h0, v);
    settle();
  endtask
  // the mailbox answers a device read a few cycles after the command write
  task automatic devRd(logic [7:0] a);
    wr(3'h2, a);
    wr(3'h4, 8'h02);
    repeat (4) @(posedge clk);
    rd(3'h5);
  endtask
  task automatic devWr(logic [7:0] a, logic [7:0] v);
    wr(3'h2, a);
    wr(3'h3, v);
    wr(3'h4, 8'h01);
    repeat (3) @(posedge clk);
  endtask
  task automatic pinA(logic [7:0] exp);
    rd(3'h1);
    check("fault pin a", exp, {7'h00, d[0]});
  endtask
  task automatic trip(logic [7:0] v);
    @(posedge clk) {overTemp, auxOcTrip, mainInUv, mainOcTrip} <= v;
    @(posedge clk) {overTemp, auxOcTrip, mainInUv, mainOcTrip} <= 8'h00;
    settle();
  endtask
  task automatic t_main();
    pins(8'h47);
    rd(3'h1);
    check("pin status on", 8'h31, d & 8'hB3);
    @(posedge clk) delivering <= 2'h2;
    settle();
    rd(3'h1);
    check("power good lost", 8'h02, d & 8'h02);
    @(posedge clk) delivering <= 2'h3;
    settle();
    devRd(8'h02);
    check("slot status on", 8'hD0, d);
    trip(8'h01);
    rd(3'h1);
    check("pin status tripped", 8'hB2, d & 8'hB3);
    devRd(8'h02);
    check("slot status tripped", 8'h85, d);
    pins(8'h45);
    pinA(8'h00);
    pins(8'h44);
    pinA(8'h01);
    devWr(8'h04, 8'h01);
    settle();
    rd(3'h1);
    check("irq after echo", 8'h00, {7'h00, d[7]});
  endtask
  task automatic t_both();
    pins(8'h47);
    trip(8'h11);
    pins(8'h46);
    pinA(8'h00);
    pins(8'h44);
    pinA(8'h01);
    pins(8'h47);
    trip(8'h40);
    pinA(8'h00);
    check("aux switch tripped", 8'h00, {7'h00, auxSwitchOn[0]});
    pins(8'h45);
    pinA(8'h01);
    devWr(8'h04, 8'h01);
    pins(8'h44);
    pins(8'h74);
    check("slot b switches", 8'h03, {6'h00, mainSwitchOn[1], auxSwitchOn[1]});
    trip(8'h02);
    rd(3'h1);
    check("fault pin b", 8'h00, {7'h00, d[4]});
    pins(8'h44);
    devWr(8'h04, 8'h02);
  endtask
  task automatic t_ovr();
    pins(8'h40);
    check("forced switches", 8'h03, {6'h00, mainSwitchOn[0], auxSwitchOn[0]});
    trip(8'h55);
    check("switches held", 8'h03, {6'h00, mainSwitchOn[0], auxSwitchOn[0]});
    rd(3'h1);
    check("pins released", 8'h33, d & 8'hB3);
    devRd(8'h02);
    check("true status", 8'hE0, d & 8'hEC);
    @(posedge clk) auxUvlo <= 1'b1;
    settle();
    check("aux lockout", 8'h02, {6'h00, mainSwitchOn[0], auxSwitchOn[0]});
    @(posedge clk) auxUvlo <= 1'b0;
    devWr(8'h00, 8'h04);
    settle();
    check("override disabled", 8'h00, {6'h00, mainSwitchOn[0], auxSwitchOn[0]});
    devWr(8'h00, 8'h00);
    pins(8'h44);
  endtask
  task automatic t_irq();
    rd(3'h6);
    wr(3'h7, 8'h01);
    devWr(8'h04, 8'h08);
    pins(8'h47);
    trip(8'h01);
    rd(3'h1);
    check("irq pin masked", 8'h00, {7'h00, d[7]});
    check("host irq masked", 8'h00, {7'h00, hostIrq});
    devWr(8'h04, 8'h00);
    settle();
    rd(3'h1);
    check("irq pin", 8'h01, {7'h00, d[7]});
    check("host irq", 8'h01, {7'h00, hostIrq});
    devWr(8'h02, 8'h00);
    devRd(8'h04);
    check("common status", 8'h41, d & 8'h4B);
    devWr(8'h04, 8'h01);
    settle();
    rd(3'h1);
    check("irq released", 8'h00, {7'h00, d[7]});
    rd(3'h6);
    wr(3'h7, 8'h00);
    pins(8'h44);
  endtask
  task automatic t_gpi();
    for (int i = 1; i < 3; i++) begin
      @(posedge clk) generalInput <= 2'(i);
      devRd(8'h04);
      check("general inputs", 8'(i), {6'h00, d[5:4]});
    end
    @(posedge clk) addrSelect <= 3'h5;
    @(posedge clk) standbyGood <= 1'b1;
    settle();
    check("bus address", 8'h45, {1'b0, smbusAddr});
    @(posedge clk) addrSelect <= 3'h2;
    settle();
    check("address kept", 8'h45, {1'b0, smbusAddr});
    devRd(8'h05);
    check("address register", 8'h45, d);
    devRd(8'h09);
    check("unmapped read", 8'h00, d);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    srst = 1'b1;
    cmdAddr = 3'h0;
    cmdWdata = 8'h00;
    cmdWr = 1'b0;
    cmdRd = 1'b0;
    {overTemp, auxOcTrip, mainInUv, mainOcTrip} = 8'h00;
    generalInput = 2'h0;
    auxUvlo = 1'b0;
    delivering = 2'h3;
    standbyGood = 1'b0;
    addrSelect = 3'h7;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_main();
    t_both();
    t_ovr();
    t_irq();
    t_gpi();
    conclude();
  end
endmodule // hpfo_tb

// *** hdl/hpfo_defs.svh ***
// register offsets, bit positions and reset values for the hot-plug fault/override logic
`ifndef HPFO_DEFS_SVH
`define HPFO_DEFS_SVH
// device registers, reached through the interface register port
`define HPFO_DEV_CTRL_A 4'h0
`define HPFO_DEV_CTRL_B 4'h1
`define HPFO_DEV_STAT_A 4'h2
`define HPFO_DEV_STAT_B 4'h3
`define HPFO_DEV_COMMON 4'h4
`define HPFO_DEV_ADDR 4'h5
// control register bits
`define HPFO_CTRL_OVR_DIS 2
// slot status bits
`define HPFO_STAT_MAIN_EVT 0
`define HPFO_STAT_AUX_EVT 1
`define HPFO_STAT_MAIN_LATCH 2
`define HPFO_STAT_AUX_LATCH 3
`define HPFO_STAT_PGOOD 4
`define HPFO_STAT_OVR 5
`define HPFO_STAT_MAIN_ON 6
`define HPFO_STAT_AUX_ON 7
// common status bits
`define HPFO_CS_EVT_A 0
`define HPFO_CS_EVT_B 1
`define HPFO_CS_IRQ_MASK 3
`define HPFO_CS_GPI_A 4
`define HPFO_CS_GPI_B 5
`define HPFO_CS_IRQ 6
`define HPFO_CS_MASK_RST 1'b0
// host user registers
`define HPFO_HOST_PINCTRL 3'h0
`define HPFO_HOST_PINSTAT 3'h1
`define HPFO_HOST_DEVADDR 3'h2
`define HPFO_HOST_DEVWDATA 3'h3
`define HPFO_HOST_DEVCMD 3'h4
`define HPFO_HOST_DEVRDATA 3'h5
`define HPFO_HOST_IRQSTAT 3'h6
`define HPFO_HOST_IRQMASK 3'h7
`define HPFO_PINCTRL_RST 8'h44
`define HPFO_IRQ_DEVIRQ 0
`define HPFO_IRQ_DONE 1
`endif

// *** hdl/hpfo_device.sv ***
// dual-slot fault latching, override, interrupt and register logic of the power controller
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "hpfo_defs.svh"
// Summary of operation
// - isolation trip drives slot fault low
// - main fault released by main enable low
// - aux fault released by aux enable low
// - both faults need both enables low
// - override low forces both supplies on
// - override ignores protections and main lockout
// - aux lockout still governs aux during override
// - override releases power-good and fault pins
// - status registers keep true supply state
// - control bit two disables slot override
// - common status shows general inputs
// - address straps sampled on standby rise
// - interrupt on fault while mask zero
// - interrupt holds until echo reset
// - main enable rising edge turns mains on
// - aux enable level gates aux output
// - power-good once slot on and delivering
module hpfo_device #(
  parameter logic [6:0] BASE_ADDR = 7'h40 // arbitrary base, low three bits come from straps
) (
  input wire logic clk,
  input wire logic srst,
  hpfo_if.dev link,
  input wire logic [1:0] mainOcTrip,
  input wire logic [1:0] mainInUv,
  input wire logic [1:0] auxOcTrip,
  input wire logic [1:0] overTemp,
  input wire logic auxUvlo,
  input wire logic [1:0] mainDelivering,
  input wire logic [1:0] auxDelivering,
  input wire logic [1:0] generalInput,
  input wire logic [2:0] addrSelect,
  input wire logic standbyGood,
  output logic [1:0] mainSwitchOn,
  output logic [1:0] auxSwitchOn,
  output logic [6:0] smbusAddr
);
  logic [1:0] mainOn_q, mainOn_d;
  logic [1:0] mainEnPrev_q, mainEnPrev_d;
  logic [1:0] mainFault_q, mainFault_d;
  logic [1:0] auxFault_q, auxFault_d;
  logic [1:0] mainEvt_q, mainEvt_d;
  logic [1:0] auxEvt_q, auxEvt_d;
  logic [1:0] ovrDis_q, ovrDis_d;
  logic [1:0] mainSw_q, mainSw_d;
  logic [1:0] auxSw_q, auxSw_d;
  logic [1:0] faultOe_q, faultOe_d;
  logic [1:0] pgOe_q, pgOe_d;
  logic [1:0] pgTrue;
  logic [1:0] override;
  logic [1:0] mainTrip, auxTrip;
  logic irqMask_q, irqMask_d;
  logic irqOe_q, irqOe_d;
  logic stbyPrev_q, stbyPrev_d;
  logic [6:0] addr_q, addr_d;
  hpfo_pkg::hpfo_byte_t rdata_q, rdata_d;
  hpfo_pkg::hpfo_byte_t stat [2];
  hpfo_pkg::hpfo_byte_t common;

  // slot power, fault latches and pin drive
  always_comb begin
    mainOn_d = mainOn_q;
    mainEnPrev_d = link.mainEnable;
    mainFault_d = mainFault_q;
    auxFault_d = auxFault_q;
    mainEvt_d = mainEvt_q;
    auxEvt_d = auxEvt_q;
    mainSw_d = mainSw_q;
    auxSw_d = auxSw_q;
    faultOe_d = faultOe_q;
    pgOe_d = pgOe_q;
    override = '0;
    pgTrue = '0;
    mainTrip = '0;
    auxTrip = '0;
    for (int s = 0; s < 2; s++) begin
      override[s] = ~link.overrideN[s] & ~ovrDis_q[s];
      // a latched fault clears only while its enable is low; a new trip wins
      if (!link.mainEnable[s]) begin
        mainFault_d[s] = 1'b0;
      end
      if (!link.auxEnable[s]) begin
        auxFault_d[s] = 1'b0;
      end
      // protections are ignored on an overridden slot
      if (!override[s] && mainSw_q[s] && (mainOcTrip[s] || mainInUv[s])) begin
        mainFault_d[s] = 1'b1;
        mainEvt_d[s] = 1'b1;
        mainTrip[s] = 1'b1;
      end
      if (!override[s] && auxSw_q[s] && (auxOcTrip[s] || overTemp[s])) begin
        auxFault_d[s] = 1'b1;
        auxEvt_d[s] = 1'b1;
        auxTrip[s] = 1'b1;
      end
      if (!link.mainEnable[s] || mainFault_d[s]) begin
        mainOn_d[s] = 1'b0;
      end else if (!mainEnPrev_q[s]) begin
        mainOn_d[s] = 1'b1;
      end
      mainSw_d[s] = override[s] | mainOn_d[s];
      // standby lockout is never bypassed
      auxSw_d[s] = ~auxUvlo & (override[s] | (link.auxEnable[s] & ~auxFault_d[s]));
      pgTrue[s] = mainOn_q[s] & auxSw_q[s] & mainDelivering[s] & auxDelivering[s];
      pgOe_d[s] = pgTrue[s] & ~override[s];
      faultOe_d[s] = (mainFault_d[s] | auxFault_d[s]) & ~override[s];
    end
    // echo reset: a one written back clears, a same-cycle trip is kept
    if (link.regWr) begin
      for (int s = 0; s < 2; s++) begin
        if (link.regAddr == (`HPFO_DEV_STAT_A + 4'(s))) begin
          if (link.regWdata[`HPFO_STAT_MAIN_EVT] && !mainTrip[s]) begin
            mainEvt_d[s] = 1'b0;
          end
          if (link.regWdata[`HPFO_STAT_AUX_EVT] && !auxTrip[s]) begin
            auxEvt_d[s] = 1'b0;
          end
        end
        if (link.regAddr == `HPFO_DEV_COMMON && link.regWdata[`HPFO_CS_EVT_A + s]) begin
          if (!mainTrip[s]) begin
            mainEvt_d[s] = 1'b0;
          end
          if (!auxTrip[s]) begin
            auxEvt_d[s] = 1'b0;
          end
        end
      end
    end
  end

  // management registers, interrupt and address strap
  always_comb begin
    ovrDis_d = ovrDis_q;
    irqMask_d = irqMask_q;
    stbyPrev_d = standbyGood;
    addr_d = addr_q;
    rdata_d = 8'h00;
    for (int s = 0; s < 2; s++) begin
      stat[s] = 8'h00;
      // live latch and switch state, not the forced pin levels
      stat[s][`HPFO_STAT_MAIN_EVT] = mainEvt_q[s];
      stat[s][`HPFO_STAT_AUX_EVT] = auxEvt_q[s];
      stat[s][`HPFO_STAT_MAIN_LATCH] = mainFault_q[s];
      stat[s][`HPFO_STAT_AUX_LATCH] = auxFault_q[s];
      stat[s][`HPFO_STAT_PGOOD] = pgTrue[s];
      stat[s][`HPFO_STAT_OVR] = override[s];
      stat[s][`HPFO_STAT_MAIN_ON] = mainSw_q[s];
      stat[s][`HPFO_STAT_AUX_ON] = auxSw_q[s];
    end
    common = 8'h00;
    common[`HPFO_CS_EVT_A] = mainEvt_q[0] | auxEvt_q[0];
    common[`HPFO_CS_EVT_B] = mainEvt_q[1] | auxEvt_q[1];
    common[`HPFO_CS_IRQ_MASK] = irqMask_q;
    common[`HPFO_CS_GPI_A] = generalInput[0];
    common[`HPFO_CS_GPI_B] = generalInput[1];
    common[`HPFO_CS_IRQ] = irqOe_q;
    if (link.regWr) begin
      case (link.regAddr)
        `HPFO_DEV_CTRL_A: ovrDis_d[0] = link.regWdata[`HPFO_CTRL_OVR_DIS];
        `HPFO_DEV_CTRL_B: ovrDis_d[1] = link.regWdata[`HPFO_CTRL_OVR_DIS];
        `HPFO_DEV_COMMON: irqMask_d = link.regWdata[`HPFO_CS_IRQ_MASK];
        default: ;
      endcase
    end
    if (link.regRd) begin
      case (link.regAddr)
        `HPFO_DEV_CTRL_A: rdata_d = {5'h00, ovrDis_q[0], 2'h0};
        `HPFO_DEV_CTRL_B: rdata_d = {5'h00, ovrDis_q[1], 2'h0};
        `HPFO_DEV_STAT_A: rdata_d = stat[0];
        `HPFO_DEV_STAT_B: rdata_d = stat[1];
        `HPFO_DEV_COMMON: rdata_d = common;
        `HPFO_DEV_ADDR: rdata_d = {1'b0, addr_q};
        default: rdata_d = 8'h00;
      endcase
    end
    // open straps read high through the internal pull-ups
    if (standbyGood && !stbyPrev_q) begin
      addr_d = BASE_ADDR | {4'h0, addrSelect};
    end
    irqOe_d = (|mainEvt_d | |auxEvt_d) & ~irqMask_d;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mainOn_q <= '0;
      mainEnPrev_q <= '1;
      mainFault_q <= '0;
      auxFault_q <= '0;
      mainEvt_q <= '0;
      auxEvt_q <= '0;
      mainSw_q <= '0;
      auxSw_q <= '0;
      faultOe_q <= '0;
      pgOe_q <= '0;
      ovrDis_q <= '0;
      irqMask_q <= `HPFO_CS_MASK_RST;
      irqOe_q <= 1'b0;
      stbyPrev_q <= 1'b0;
      addr_q <= '0;
      rdata_q <= 8'h00;
    end else begin
      mainOn_q <= mainOn_d;
      mainEnPrev_q <= mainEnPrev_d;
      mainFault_q <= mainFault_d;
      auxFault_q <= auxFault_d;
      mainEvt_q <= mainEvt_d;
      auxEvt_q <= auxEvt_d;
      mainSw_q <= mainSw_d;
      auxSw_q <= auxSw_d;
      faultOe_q <= faultOe_d;
      pgOe_q <= pgOe_d;
      ovrDis_q <= ovrDis_d;
      irqMask_q <= irqMask_d;
      irqOe_q <= irqOe_d;
      stbyPrev_q <= stbyPrev_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
    end
  end

  assign link.faultOut = 2'b00;
  assign link.faultOe = faultOe_q;
  assign link.powerGoodOut = 2'b00;
  assign link.powerGoodOe = pgOe_q;
  assign link.irqOut = 1'b0;
  assign link.irqOe = irqOe_q;
  assign link.regRdata = rdata_q;
  assign mainSwitchOn = mainSw_q;
  assign auxSwitchOn = auxSw_q;
  assign smbusAddr = addr_q;
endmodule // hpfo_device

// *** hdl/hpfo_host.sv ***
// management host end: enable pins, device register mailbox and host interrupt
`timescale 1ns/1ps
`include "hpfo_defs.svh"
module hpfo_host (
  input wire logic clk,
  input wire logic srst,
  hpfo_if.host link,
  input wire logic [2:0] cmdAddr,
  input wire logic [7:0] cmdWdata,
  input wire logic cmdWr,
  input wire logic cmdRd,
  output logic [7:0] cmdRdata,
  output logic hostIrq
);
  hpfo_pkg::hpfo_host_state_t state_q, state_d;
  hpfo_pkg::hpfo_byte_t pinCtrl_q, pinCtrl_d;
  hpfo_pkg::hpfo_addr_t devAddr_q, devAddr_d;
  hpfo_pkg::hpfo_byte_t devWdata_q, devWdata_d;
  hpfo_pkg::hpfo_byte_t devRdata_q, devRdata_d;
  logic devWr_q, devWr_d;
  logic devRd_q, devRd_d;
  logic [1:0] irqStat_q, irqStat_d;
  logic [1:0] irqMask_q, irqMask_d;
  logic hostIrq_q, hostIrq_d;
  hpfo_pkg::hpfo_byte_t rdata_q, rdata_d;
  logic [1:0] irqSet;
  logic busy;

  always_comb begin
    state_d = state_q;
    pinCtrl_d = pinCtrl_q;
    devAddr_d = devAddr_q;
    devWdata_d = devWdata_q;
    devRdata_d = devRdata_q;
    devWr_d = 1'b0;
    devRd_d = 1'b0;
    irqMask_d = irqMask_q;
    rdata_d = 8'h00;
    busy = (state_q != hpfo_pkg::HPFO_IDLE) | devWr_q;
    irqSet = {1'b0, ~link.irqN};
    case (state_q)
      hpfo_pkg::HPFO_IDLE: begin
        if (cmdWr && cmdAddr == `HPFO_HOST_DEVCMD && !busy) begin
          if (cmdWdata[0]) begin
            devWr_d = 1'b1;
          end else if (cmdWdata[1]) begin
            devRd_d = 1'b1;
            state_d = hpfo_pkg::HPFO_ISSUE_RD;
          end
        end
      end
      hpfo_pkg::HPFO_ISSUE_RD: state_d = hpfo_pkg::HPFO_CAPTURE;
      hpfo_pkg::HPFO_CAPTURE: begin
        devRdata_d = link.regRdata;
        irqSet[`HPFO_IRQ_DONE] = 1'b1;
        state_d = hpfo_pkg::HPFO_IDLE;
      end
      default: state_d = hpfo_pkg::HPFO_IDLE;
    endcase
    if (devWr_q) begin
      irqSet[`HPFO_IRQ_DONE] = 1'b1;
    end
    // enable pins follow software; a low-to-high write gives the main turn-on edge
    if (cmdWr) begin
      case (cmdAddr)
        `HPFO_HOST_PINCTRL: pinCtrl_d = cmdWdata;
        `HPFO_HOST_DEVADDR: devAddr_d = cmdWdata[3:0];
        `HPFO_HOST_DEVWDATA: devWdata_d = cmdWdata;
        `HPFO_HOST_IRQMASK: irqMask_d = cmdWdata[1:0];
        default: ;
      endcase
    end
    // sticky status cleared by a read; a same-cycle event wins
    irqStat_d = irqStat_q | irqSet;
    if (cmdRd) begin
      case (cmdAddr)
        `HPFO_HOST_PINCTRL: rdata_d = pinCtrl_q;
        `HPFO_HOST_PINSTAT: rdata_d = {~link.irqN, 1'b0, link.powerGoodN[1], link.faultN[1],
                                       2'h0, link.powerGoodN[0], link.faultN[0]};
        `HPFO_HOST_DEVADDR: rdata_d = {4'h0, devAddr_q};
        `HPFO_HOST_DEVWDATA: rdata_d = devWdata_q;
        `HPFO_HOST_DEVCMD: rdata_d = {7'h00, busy};
        `HPFO_HOST_DEVRDATA: rdata_d = devRdata_q;
        `HPFO_HOST_IRQSTAT: begin
          rdata_d = {6'h00, irqStat_q};
          irqStat_d = irqSet;
        end
        `HPFO_HOST_IRQMASK: rdata_d = {6'h00, irqMask_q};
        default: rdata_d = 8'h00;
      endcase
    end
    hostIrq_d = |(irqStat_d & irqMask_d);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= hpfo_pkg::HPFO_IDLE;
      pinCtrl_q <= `HPFO_PINCTRL_RST;
      devAddr_q <= '0;
      devWdata_q <= 8'h00;
      devRdata_q <= 8'h00;
      devWr_q <= 1'b0;
      devRd_q <= 1'b0;
      irqStat_q <= '0;
      irqMask_q <= '0;
      hostIrq_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      state_q <= state_d;
      pinCtrl_q <= pinCtrl_d;
      devAddr_q <= devAddr_d;
      devWdata_q <= devWdata_d;
      devRdata_q <= devRdata_d;
      devWr_q <= devWr_d;
      devRd_q <= devRd_d;
      irqStat_q <= irqStat_d;
      irqMask_q <= irqMask_d;
      hostIrq_q <= hostIrq_d;
      rdata_q <= rdata_d;
    end
  end

  assign link.mainEnable = {pinCtrl_q[4], pinCtrl_q[0]};
  assign link.auxEnable = {pinCtrl_q[5], pinCtrl_q[1]};
  assign link.overrideN = {pinCtrl_q[6], pinCtrl_q[2]};
  assign link.regAddr = devAddr_q;
  assign link.regWdata = devWdata_q;
  assign link.regWr = devWr_q;
  assign link.regRd = devRd_q;
  assign cmdRdata = rdata_q;
  assign hostIrq = hostIrq_q;
endmodule // hpfo_host

// *** hdl/hpfo_if.sv ***
// pins between the slot controller and the management host, with pull-up resolution
`timescale 1ns/1ps
interface hpfo_if;
  logic [1:0] mainEnable;
  logic [1:0] auxEnable;
  logic [1:0] overrideN;
  logic [1:0] faultOut;
  logic [1:0] faultOe;
  logic [1:0] powerGoodOut;
  logic [1:0] powerGoodOe;
  logic irqOut;
  logic irqOe;
  logic [1:0] faultN;
  logic [1:0] powerGoodN;
  logic irqN;
  hpfo_pkg::hpfo_addr_t regAddr;
  hpfo_pkg::hpfo_byte_t regWdata;
  logic regWr;
  logic regRd;
  hpfo_pkg::hpfo_byte_t regRdata;
  // open-drain lines with external pull-ups: low only while driven low
  assign faultN = ~faultOe | faultOut;
  assign powerGoodN = ~powerGoodOe | powerGoodOut;
  assign irqN = ~irqOe | irqOut;
  modport dev (
    input mainEnable, auxEnable, overrideN, regAddr, regWdata, regWr, regRd,
    output faultOut, faultOe, powerGoodOut, powerGoodOe, irqOut, irqOe, regRdata
  );
  modport host (
    output mainEnable, auxEnable, overrideN, regAddr, regWdata, regWr, regRd,
    input faultN, powerGoodN, irqN, regRdata
  );
endinterface

// *** hdl/hpfo_pkg.sv ***
// types shared by both ends of the hot-plug fault/override logic
package hpfo_pkg;
  typedef logic [7:0] hpfo_byte_t;
  typedef logic [3:0] hpfo_addr_t;
  typedef enum logic [1:0] {HPFO_IDLE, HPFO_ISSUE_RD, HPFO_CAPTURE} hpfo_host_state_t;
endpackage
